// [logic/tcc_pkg.sv]
// package: register map, fields, reset values and modes of the timer
package tcc_pkg;
    // register byte addresses (byte address = index * 4)
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CFG     = 8'h04;
    localparam logic [7:0] ADDR_COUNT   = 8'h08;
    localparam logic [7:0] ADDR_RELOAD  = 8'h0c;
    localparam logic [7:0] ADDR_CAPTURE = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h1c;

    // control register field positions
    localparam int CTRL_EN_BIT    = 7;
    localparam int CTRL_POL_BIT   = 6;
    localparam int CTRL_PRE_LSB   = 3;
    localparam int CTRL_MODE_LSB  = 0;
    // configuration register field positions
    localparam int CFG_OUT_EN_BIT = 2;
    localparam int CFG_IRQSEL_LSB = 0;

    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam logic [15:0] COUNT_RESET  = 16'h0001;
    localparam logic [15:0] RELOAD_RESET = 16'hffff;
    localparam logic [15:0] COUNT_WRAP   = 16'h0001;
    localparam logic [15:0] CAPT_CLEAR   = 16'h0000;

    // status bit positions
    localparam int ST_RELOAD  = 0;
    localparam int ST_CAPTURE = 1;
    localparam int ST_COMPARE = 2;
    localparam int ST_W       = 3;

    typedef enum logic [1:0] {
        TCC_MODE_COMPARE = 2'h0,
        TCC_MODE_CAPTURE = 2'h1,
        TCC_MODE_CMPCNT  = 2'h2,
        TCC_MODE_RSVD    = 2'h3
    } tcc_mode_t;

    typedef enum logic [1:0] {
        TCC_IRQ_BOTH    = 2'h0,
        TCC_IRQ_BOTH2   = 2'h1,
        TCC_IRQ_CAPTURE = 2'h2,
        TCC_IRQ_RELOAD  = 2'h3
    } tcc_irqsel_t;

    // register bus request carried as one bundle
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tcc_bus_req_t;
endpackage : tcc_pkg

// [logic/tcc_edge_sync.sv]
// two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // edges seen on the settled copy only
    assign level = sync_q;
    assign rise  = sync_q & ~last_q;
    assign fall  = ~sync_q & last_q;
endmodule : tcc_edge_sync
`default_nettype wire

// [logic/tcc_timer.sv]
// 16-bit compare / capture / comparator-counter timer with register port
// Functional notes
// - comparator reload: interrupt, count to 0001H
// - output toggles on each comparator reload
// - polarity picks edge and initial level
// - start count only for first pass
// - capture irq: both, capture-only, reload-only
// - capture copies count; reload leaves it
// - capture mode counts once per prescale
// - capture event from timer input pin
// - compare counts clocks toward reload value
// - compare match interrupts, count continues
// - output toggles on each compare match
// - compare count wraps FFFFH to 0000H
// - control holds prescale and initial level
// - comparator count rises one per edge
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire tcc_pkg::tcc_bus_req_t bus_req,
    output logic [31:0]             rdata,
    input  wire logic               cmp_out,
    input  wire logic               tin_pin,
    output logic                    tout,
    output logic                    irq
);
    logic [7:0]       ctrl_q;
    logic [7:0]       cfg_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] reload_q;
    logic [CNT_W-1:0] capt_q;
    logic [CNT_W-1:0] capt_d;
    logic [6:0]       pre_cnt_q;
    logic [6:0]       pre_cnt_d;
    logic             tout_q;
    logic             tout_d;
    logic [tcc_pkg::ST_W-1:0] status_q;
    logic [tcc_pkg::ST_W-1:0] status_d;
    logic [tcc_pkg::ST_W-1:0] irq_en_q;
    logic [tcc_pkg::ST_W-1:0] ev;
    logic [31:0]      rdata_q;
    logic [31:0]      rd_mux;

    wire logic wr = bus_req.wr;
    wire logic rd = bus_req.rd;

    // register field decode
    wire logic              en     = ctrl_q[tcc_pkg::CTRL_EN_BIT];
    wire logic              pol    = ctrl_q[tcc_pkg::CTRL_POL_BIT];
    wire logic [2:0]        pre    = ctrl_q[tcc_pkg::CTRL_PRE_LSB +: 3];
    wire tcc_pkg::tcc_mode_t mode  =
        tcc_pkg::tcc_mode_t'(ctrl_q[tcc_pkg::CTRL_MODE_LSB +: 2]);
    wire logic              out_en = cfg_q[tcc_pkg::CFG_OUT_EN_BIT];
    wire tcc_pkg::tcc_irqsel_t irqsel =
        tcc_pkg::tcc_irqsel_t'(cfg_q[tcc_pkg::CFG_IRQSEL_LSB +: 2]);

    // prescale divide = 2^pre, up to 128
    function automatic logic [6:0] pre_max(input logic [2:0] p);
        pre_max = 7'((8'h01 << p) - 8'h01);
    endfunction

    // address match for the register port
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // synchronised comparator and input pin
    logic cmp_lvl;
    logic cmp_rise;
    logic cmp_fall;
    logic tin_lvl;
    logic tin_rise;
    logic tin_fall;

    tcc_edge_sync u_cmp_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (cmp_out),
        .level    (cmp_lvl),
        .rise     (cmp_rise),
        .fall     (cmp_fall)
    );

    tcc_edge_sync u_tin_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (tin_pin),
        .level    (tin_lvl),
        .rise     (tin_rise),
        .fall     (tin_fall)
    );

    // comparator edge of chosen polarity; source must stay under sysclk/4
    wire logic cmp_tick  = pol ? cmp_fall : cmp_rise;
    // capture event on timer input pin, same polarity selection
    wire logic capt_ev   = pol ? tin_fall : tin_rise;
    wire logic pre_tick  = (pre_cnt_q == pre_max(pre));
    wire logic at_reload = (count_q == reload_q);
    wire logic is_cc     = (mode == tcc_pkg::TCC_MODE_CMPCNT);
    wire logic is_cap    = (mode == tcc_pkg::TCC_MODE_CAPTURE);
    wire logic is_cmp    = (mode == tcc_pkg::TCC_MODE_COMPARE);

    // event strobes, all silent while disabled
    wire logic cc_reload  = en & is_cc & cmp_tick & at_reload;
    wire logic cap_reload = en & is_cap & pre_tick & at_reload;
    wire logic cap_take   = en & is_cap & capt_ev;
    wire logic cmp_match  = en & is_cmp & pre_tick & at_reload;
    wire logic cap_irq_ok = (irqsel != tcc_pkg::TCC_IRQ_RELOAD);
    wire logic rel_irq_ok = (irqsel != tcc_pkg::TCC_IRQ_CAPTURE);

    // prescaler runs only while enabled, in every mode but comparator counter
    always_comb begin
        pre_cnt_d = pre_cnt_q;
        if (!en || is_cc || pre_tick) begin
            pre_cnt_d = 7'h00;
        end else begin
            pre_cnt_d = 7'(pre_cnt_q + 7'h01);
        end
    end

    // counter next value
    always_comb begin
        count_d = count_q;
        if (wr && hit(bus_req.addr, tcc_pkg::ADDR_COUNT)) begin
            count_d = bus_req.wdata[CNT_W-1:0];
        end else if (!en) begin
            count_d = count_q;
        end else if (is_cc && cmp_tick) begin
            if (at_reload) begin
                count_d = tcc_pkg::COUNT_WRAP;
            end else begin
                count_d = CNT_W'(count_q + 1'b1);
            end
        end else if (is_cap && pre_tick) begin
            if (at_reload) begin
                count_d = tcc_pkg::COUNT_WRAP;
            end else begin
                count_d = CNT_W'(count_q + 1'b1);
            end
        end else if (is_cmp && pre_tick) begin
            // no reset at match; natural wrap to zero
            count_d = CNT_W'(count_q + 1'b1);
        end
    end

    // capture register: only capture events or software touch it
    always_comb begin
        capt_d = capt_q;
        if (cap_take) begin
            capt_d = count_q;
        end else if (wr && hit(bus_req.addr, tcc_pkg::ADDR_CAPTURE)) begin
            capt_d = bus_req.wdata[CNT_W-1:0];
        end
    end

    // output level: polarity sets it while disabled, toggles on events
    always_comb begin
        tout_d = tout_q;
        if (!en) begin
            tout_d = pol;
        end else if (out_en && (cc_reload || cmp_match)) begin
            tout_d = ~tout_q;
        end
    end

    // sticky events; set wins over a same-cycle clear
    assign ev[tcc_pkg::ST_RELOAD]  = cc_reload | (cap_reload & rel_irq_ok);
    assign ev[tcc_pkg::ST_CAPTURE] = cap_take & cap_irq_ok;
    assign ev[tcc_pkg::ST_COMPARE] = cmp_match;

    always_comb begin
        status_d = status_q;
        if (wr && hit(bus_req.addr, tcc_pkg::ADDR_IRQ_CLR)) begin
            status_d = status_q & ~bus_req.wdata[tcc_pkg::ST_W-1:0];
        end
        status_d = status_d | ev;
    end

    // read data mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (bus_req.addr)
            tcc_pkg::ADDR_CTRL:    rd_mux[7:0] = ctrl_q;
            tcc_pkg::ADDR_CFG:     rd_mux[7:0] = cfg_q;
            tcc_pkg::ADDR_COUNT:   rd_mux[CNT_W-1:0] = count_q;
            tcc_pkg::ADDR_RELOAD:  rd_mux[CNT_W-1:0] = reload_q;
            tcc_pkg::ADDR_CAPTURE: rd_mux[CNT_W-1:0] = capt_q;
            tcc_pkg::ADDR_STATUS:  rd_mux[tcc_pkg::ST_W-1:0] = status_q;
            tcc_pkg::ADDR_IRQ_EN:  rd_mux[tcc_pkg::ST_W-1:0] = irq_en_q;
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // configuration registers; software keeps timer off while editing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q   <= tcc_pkg::CTRL_RESET;
            cfg_q    <= tcc_pkg::CFG_RESET;
            reload_q <= tcc_pkg::RELOAD_RESET;
            irq_en_q <= '0;
        end else if (wr) begin
            if (hit(bus_req.addr, tcc_pkg::ADDR_CTRL)) begin
                ctrl_q <= bus_req.wdata[7:0];
            end
            if (hit(bus_req.addr, tcc_pkg::ADDR_CFG)) begin
                cfg_q <= bus_req.wdata[7:0];
            end
            if (hit(bus_req.addr, tcc_pkg::ADDR_RELOAD)) begin
                reload_q <= bus_req.wdata[CNT_W-1:0];
            end
            if (hit(bus_req.addr, tcc_pkg::ADDR_IRQ_EN)) begin
                irq_en_q <= bus_req.wdata[tcc_pkg::ST_W-1:0];
            end
        end
    end

    // datapath state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q   <= tcc_pkg::COUNT_RESET;
            capt_q    <= tcc_pkg::CAPT_CLEAR;
            pre_cnt_q <= 7'h00;
            tout_q    <= 1'b0;
            status_q  <= '0;
            rdata_q   <= 32'h0000_0000;
        end else begin
            count_q   <= count_d;
            capt_q    <= capt_d;
            pre_cnt_q <= pre_cnt_d;
            tout_q    <= tout_d;
            status_q  <= status_d;
            rdata_q   <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign rdata = rdata_q;
    assign tout  = tout_q;
    assign irq   = |(status_q & irq_en_q);

    // assertions
    property p_cc_wrap;
        @(posedge sys_clk) disable iff (rst)
        (cc_reload && !(wr && hit(bus_req.addr, tcc_pkg::ADDR_COUNT)))
        |=> (count_q == 16'h0001) && status_q[tcc_pkg::ST_RELOAD];
    endproperty
    a_cc_wrap: assert property (p_cc_wrap)
        else $error("comparator reload did not wrap to one");

    property p_cc_toggle;
        @(posedge sys_clk) disable iff (rst)
        (cc_reload && out_en) |=> (tout_q != $past(tout_q));
    endproperty
    a_cc_toggle: assert property (p_cc_toggle)
        else $error("output did not toggle on reload");

    property p_idle_level;
        @(posedge sys_clk) disable iff (rst)
        (!en && !wr) ##1 !en |-> (tout_q == pol);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("idle output level not polarity");

    property p_cc_step;
        @(posedge sys_clk) disable iff (rst)
        (en && is_cc && cmp_tick && !at_reload && !wr)
        |=> count_q == 16'($past(count_q) + 16'h0001);
    endproperty
    a_cc_step: assert property (p_cc_step)
        else $error("comparator count step wrong");

    property p_capt_copy;
        @(posedge sys_clk) disable iff (rst)
        cap_take |=> (capt_q == $past(count_q));
    endproperty
    a_capt_copy: assert property (p_capt_copy)
        else $error("capture value not taken");

    property p_capt_keep;
        @(posedge sys_clk) disable iff (rst)
        (cap_reload && !cap_take && !wr) |=> $stable(capt_q);
    endproperty
    a_capt_keep: assert property (p_capt_keep)
        else $error("reload changed capture value");

    property p_irq_sel;
        @(posedge sys_clk) disable iff (rst)
        (irqsel == tcc_pkg::TCC_IRQ_RELOAD && !status_q[tcc_pkg::ST_CAPTURE])
        |=> !status_q[tcc_pkg::ST_CAPTURE];
    endproperty
    a_irq_sel: assert property (p_irq_sel)
        else $error("capture flagged in reload-only setting");

    property p_cmp_cont;
        @(posedge sys_clk) disable iff (rst)
        (cmp_match && !wr) |=> (count_q == 16'($past(count_q) + 16'h0001))
            && status_q[tcc_pkg::ST_COMPARE];
    endproperty
    a_cmp_cont: assert property (p_cmp_cont)
        else $error("compare match reset the count");

    property p_cmp_wrap;
        @(posedge sys_clk) disable iff (rst)
        (en && is_cmp && pre_tick && count_q == 16'hffff && !wr)
        |=> (count_q == 16'h0000);
    endproperty
    a_cmp_wrap: assert property (p_cmp_wrap)
        else $error("compare count did not roll over");

    property p_hold;
        @(posedge sys_clk) disable iff (rst)
        (!en && !wr) |=> $stable(count_q) && (ev == '0);
    endproperty
    a_hold: assert property (p_hold)
        else $error("disabled timer moved");

    // pin edge judged on the synchronised copy, one sample low then high
    sequence s_tin_rise;
        !tin_lvl ##1 tin_lvl;
    endsequence

    property p_capt_pin;
        @(posedge sys_clk) disable iff (rst)
        (s_tin_rise ##0 (en && is_cap && !pol))
        |=> (capt_q == $past(count_q));
    endproperty
    a_capt_pin: assert property (p_capt_pin)
        else $error("capture missed a pin edge");

    sequence s_cmp_rise;
        !cmp_lvl ##1 cmp_lvl;
    endsequence

    property p_cc_edge;
        @(posedge sys_clk) disable iff (rst)
        (s_cmp_rise ##0 (en && is_cc && !pol && !at_reload && !wr))
        |=> count_q == 16'($past(count_q) + 16'h0001);
    endproperty
    a_cc_edge: assert property (p_cc_edge)
        else $error("comparator count missed chosen edge");

    property p_cmp_toggle;
        @(posedge sys_clk) disable iff (rst)
        (cmp_match && out_en) |=> (tout_q != $past(tout_q));
    endproperty
    a_cmp_toggle: assert property (p_cmp_toggle)
        else $error("output did not toggle on compare");

    property p_cap_hold;
        @(posedge sys_clk) disable iff (rst)
        (en && is_cap && !pre_tick && !wr) |=> $stable(count_q);
    endproperty
    a_cap_hold: assert property (p_cap_hold)
        else $error("capture count moved between prescale ticks");
endmodule : tcc_timer
`default_nettype wire

// [dv/tcc_pin_model.sv]
// partner model: comparator output and timer input pin sources
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
    input  wire logic sys_clk,
    output var logic  cmp_out,
    output var logic  tin_pin
);
    // both sources idle low from time zero
    initial begin
        cmp_out = 1'b0;
        tin_pin = 1'b0;
    end

    // each level held two clocks, so never faster than sysclk/4
    task automatic cmp_pulses(input int n);
        repeat (n) begin
            @(posedge sys_clk) cmp_out <= 1'b1;
            repeat (2) @(posedge sys_clk);
            cmp_out <= 1'b0;
            @(posedge sys_clk);
        end
        repeat (6) @(posedge sys_clk); // sync plus edge detect latency
    endtask

    // one rising edge on the timer input pin, then back low
    task automatic tin_pulse();
        @(posedge sys_clk) tin_pin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        tin_pin <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // tcc_pin_model
`default_nettype wire

// [dv/tb.sv]
// self-checking testbench for the compare/capture/comparator timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                  sys_clk;
    logic                  rst;
    logic                  cmp_out;
    logic                  tin_pin;
    logic                  tout;
    logic                  irq;
    logic [31:0]           rdata;
    logic [31:0]           v;
    tcc_pkg::tcc_bus_req_t bus_req;
    int                    fails;
    int                    cmp_count;

    tcc_timer tcc_timer_inst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bus_req (bus_req),
        .rdata   (rdata),
        .cmp_out (cmp_out),
        .tin_pin (tin_pin),
        .tout    (tout),
        .irq     (irq)
    );

    tcc_pin_model pin_model_inst (
        .sys_clk (sys_clk),
        .cmp_out (cmp_out),
        .tin_pin (tin_pin)
    );

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // one-cycle write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk) bus_req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk) bus_req.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(v, exp);
    endtask

    // reset values, unmapped and write-only places read zero
    task automatic t_reset();
        rchk(tcc_pkg::ADDR_CTRL, 32'h0);
        rchk(tcc_pkg::ADDR_CFG, 32'h0);
        rchk(tcc_pkg::ADDR_COUNT, 32'h1);
        rchk(tcc_pkg::ADDR_RELOAD, 32'hffff);
        rchk(tcc_pkg::ADDR_CAPTURE, 32'h0);
        rchk(tcc_pkg::ADDR_STATUS, 32'h0);
        rchk(tcc_pkg::ADDR_IRQ_CLR, 32'h0);
        rchk(8'h40, 32'h0);
        @(posedge sys_clk) #1 chk(rdata, 32'h0);
        chk({tout, irq}, 32'h0);
    endtask

    // comparator counter: start value, reload, toggle, hold, irq
    task automatic t_cmpcnt();
        wr(tcc_pkg::ADDR_CTRL, 32'h42);
        repeat (2) @(posedge sys_clk);
        #1 chk(tout, 1'b1);
        wr(tcc_pkg::ADDR_CTRL, 32'h02);
        repeat (2) @(posedge sys_clk);
        #1 chk(tout, 1'b0);
        wr(tcc_pkg::ADDR_COUNT, 32'h5);
        wr(tcc_pkg::ADDR_RELOAD, 32'h8);
        wr(tcc_pkg::ADDR_CFG, 32'h4);
        wr(tcc_pkg::ADDR_IRQ_EN, 32'h1);
        wr(tcc_pkg::ADDR_CTRL, 32'h82);
        pin_model_inst.cmp_pulses(3);
        rchk(tcc_pkg::ADDR_COUNT, 32'h8);
        chk({tout, irq}, 32'h0);
        pin_model_inst.cmp_pulses(1);
        rchk(tcc_pkg::ADDR_COUNT, 32'h1);
        rchk(tcc_pkg::ADDR_STATUS, 32'h1);
        chk({tout, irq}, 32'h3);
        pin_model_inst.cmp_pulses(2);
        rchk(tcc_pkg::ADDR_COUNT, 32'h3);
        wr(tcc_pkg::ADDR_CTRL, 32'h02);
        pin_model_inst.cmp_pulses(2);
        rchk(tcc_pkg::ADDR_COUNT, 32'h3);
        wr(tcc_pkg::ADDR_IRQ_EN, 32'h0);
        #1 chk(irq, 1'b0);
        wr(tcc_pkg::ADDR_IRQ_EN, 32'h1);
        wr(tcc_pkg::ADDR_IRQ_CLR, 32'h7);
        #1 chk(irq, 1'b0);
        rchk(tcc_pkg::ADDR_STATUS, 32'h0);
    endtask

    // capture: prescaled count, copy on pin edge, irq selection
    task automatic t_capture();
        wr(tcc_pkg::ADDR_CTRL, 32'h11);
        wr(tcc_pkg::ADDR_COUNT, 32'h1);
        wr(tcc_pkg::ADDR_RELOAD, 32'hffff);
        wr(tcc_pkg::ADDR_CAPTURE, 32'h0);
        wr(tcc_pkg::ADDR_CFG, 32'h2);
        wr(tcc_pkg::ADDR_IRQ_EN, 32'h7);
        wr(tcc_pkg::ADDR_CTRL, 32'h91);
        repeat (40) @(posedge sys_clk);
        pin_model_inst.tin_pulse();
        wr(tcc_pkg::ADDR_CTRL, 32'h11);
        rd(tcc_pkg::ADDR_CAPTURE);
        chk(v inside {[32'd9:32'd14]}, 1'b1);
        rd(tcc_pkg::ADDR_COUNT);
        chk(v inside {[32'd12:32'd16]}, 1'b1);
        rchk(tcc_pkg::ADDR_STATUS, 32'h2);
        chk(irq, 1'b1);
        wr(tcc_pkg::ADDR_IRQ_CLR, 32'h7);
        wr(tcc_pkg::ADDR_CFG, 32'h3);
        wr(tcc_pkg::ADDR_CAPTURE, 32'h0);
        wr(tcc_pkg::ADDR_CTRL, 32'h91);
        pin_model_inst.tin_pulse();
        wr(tcc_pkg::ADDR_CTRL, 32'h11);
        chk(irq, 1'b0);
        rd(tcc_pkg::ADDR_CAPTURE);
        chk(v != 32'h0, 1'b1);
        // reload with no pin activity leaves the capture value alone
        wr(tcc_pkg::ADDR_CFG, 32'h0);
        wr(tcc_pkg::ADDR_CAPTURE, 32'h0);
        wr(tcc_pkg::ADDR_COUNT, 32'h1);
        wr(tcc_pkg::ADDR_RELOAD, 32'h3);
        wr(tcc_pkg::ADDR_IRQ_CLR, 32'h7);
        wr(tcc_pkg::ADDR_CTRL, 32'h81);
        repeat (10) @(posedge sys_clk);
        wr(tcc_pkg::ADDR_CTRL, 32'h01);
        rchk(tcc_pkg::ADDR_STATUS, 32'h1);
        rchk(tcc_pkg::ADDR_CAPTURE, 32'h0);
        chk(irq, 1'b1);
    endtask

    // compare: match irq without reset, toggle, wrap, hold
    task automatic t_compare();
        int n;
        n = 0;
        wr(tcc_pkg::ADDR_CTRL, 32'h00);
        wr(tcc_pkg::ADDR_IRQ_CLR, 32'h7);
        wr(tcc_pkg::ADDR_COUNT, 32'hfff0);
        wr(tcc_pkg::ADDR_RELOAD, 32'hfff8);
        wr(tcc_pkg::ADDR_CFG, 32'h4);
        wr(tcc_pkg::ADDR_IRQ_EN, 32'h4);
        wr(tcc_pkg::ADDR_CTRL, 32'h80);
        // bounded wait for the match
        while (irq !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        chk(irq, 1'b1);
        rd(tcc_pkg::ADDR_COUNT);
        chk(v inside {[32'hfff8:32'hffff]}, 1'b1);
        chk(tout, 1'b1);
        repeat (15) @(posedge sys_clk);
        wr(tcc_pkg::ADDR_CTRL, 32'h00);
        rd(tcc_pkg::ADDR_COUNT);
        chk(v inside {[32'h0:32'h30]}, 1'b1);
        repeat (20) @(posedge sys_clk);
        rchk(tcc_pkg::ADDR_COUNT, v);
        rchk(tcc_pkg::ADDR_STATUS, 32'h4);
    endtask

    // watchdog: far beyond the few hundred cycles the tests need
    initial begin
        #2_000_000;
        fails++;
        give_verdict();
    end

    // reset for eight cycles, then the scenarios in turn
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        bus_req = '0;
        fails = 0;
        cmp_count = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_cmpcnt();
        t_capture();
        t_compare();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
